//--- design/rsp_bus_if.sv
// Purpose: processor-side bus between master and region slave port
// Assumes: single ref_clk domain
// Notes:   no pipelined reads: one read outstanding at a time
`timescale 1ns/1ps
`default_nettype none
`include "rsp_cfg.svh"
interface rsp_bus_if;
  logic [`RSP_ADDR_W-1:0] address;
  logic [`RSP_DATA_W-1:0] writedata;
  logic                   write;
  logic                   read;
  logic [`RSP_DATA_W-1:0] readdata;
  logic                   readdatavalid;
  modport master
  (
    output address,
    output writedata,
    output write,
    output read,
    input  readdata,
    input  readdatavalid
  );
  modport slave
  (
    input  address,
    input  writedata,
    input  write,
    input  read,
    output readdata,
    output readdatavalid
  );
endinterface
`default_nettype wire

//--- design/rsp_cfg.svh
// Purpose: constants shared by both ends of the region slave link
// Assumes: word addressing on the processor bus
// Notes:   timing counts are in ref_clk cycles
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH
`define RSP_ADDR_W      16
`define RSP_DATA_W      32
`define RSP_BASE_ADDR   16'h0100
`define RSP_NUM_WORDS   16'h0010
`define RSP_RD_TIMEOUT  8'h10
`endif

//--- design/rsp_pkg.sv
// Purpose: types for the region slave port and its bus master
// Assumes: nothing beyond rsp_cfg.svh
// Notes:   access modes of the window
package rsp_pkg;
  typedef enum logic [1:0]
  {
    RSP_MODE_READ,
    RSP_MODE_WRITE,
    RSP_MODE_RDWR,
    RSP_MODE_CONST
  } rsp_mode_type;
endpackage

//--- design/rsp_region_slave_port.sv
// Purpose: forwards bus accesses inside one window to user logic
// Assumes: user logic in the same clock domain, answers reads itself
// Notes:   reads are not pipelined; a window read blocks new reads
`timescale 1ns/1ps
`default_nettype none
`include "rsp_cfg.svh"
module rsp_region_slave_port
#(
  parameter int                   DATA_W    = `RSP_DATA_W,
  parameter int                   ADDR_W    = `RSP_ADDR_W,
  parameter logic [ADDR_W-1:0]    BASE_ADDR = `RSP_BASE_ADDR,
  parameter logic [ADDR_W-1:0]    NUM_WORDS = `RSP_NUM_WORDS,
  parameter rsp_pkg::rsp_mode_type MODE     = rsp_pkg::RSP_MODE_RDWR
)
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  rsp_bus_if.slave               bus,
  output var  logic [ADDR_W-1:0] userAddr,
  output var  logic [DATA_W-1:0] userWrData,
  output var  logic              userWrEn,
  output var  logic              userRdEn,
  input  wire logic [DATA_W-1:0] userRdData,
  input  wire logic              respReadValid
);
  import rsp_pkg::*;

  // ********************************
  // parameter checks
  // ********************************
  // widths limited to bus words
  if (DATA_W != 16 && DATA_W != 32)
  begin : gen_bad_data_w
    $error("data width must be 16 or 32");
  end

  // a window that wraps would alias low addresses
  if (ADDR_W < 31 && int'(BASE_ADDR) + int'(NUM_WORDS) > (1 << ADDR_W))
  begin : gen_bad_window
    $error("window runs past the top of the address space");
  end

  // ********************************
  // window decode
  // ********************************
  function automatic logic inWindow(input logic [ADDR_W-1:0] a);
    inWindow = (a >= BASE_ADDR) && ((a - BASE_ADDR) < NUM_WORDS);
  endfunction

  function automatic logic [ADDR_W-1:0] winOffset
  (
    input logic [ADDR_W-1:0] a
  );
    winOffset = a - BASE_ADDR;
  endfunction

  // mode gating
  // constant mode takes nothing but keeps its range
  function automatic logic modeWrites(input rsp_mode_type m);
    modeWrites = (m == RSP_MODE_WRITE) || (m == RSP_MODE_RDWR);
  endfunction

  function automatic logic modeReads(input rsp_mode_type m);
    modeReads = (m == RSP_MODE_READ) || (m == RSP_MODE_RDWR);
  endfunction

  // ********************************
  // state and decode terms
  // ********************************
  logic [ADDR_W-1:0] userAddr_r,   userAddr_nxt;
  logic [DATA_W-1:0] userWrData_r, userWrData_nxt;
  logic              userWrEn_r,   userWrEn_nxt;
  logic              userRdEn_r,   userRdEn_nxt;
  logic              busy_r,       busy_nxt;
  logic [DATA_W-1:0] rdData_r,     rdData_nxt;
  logic              rdValid_r,    rdValid_nxt;

  logic [ADDR_W-1:0] busAddr;
  logic              hit;
  logic              wrOk;
  logic              rdOk;
  logic              wrTake;
  logic              rdTake;
  logic              rdDone;

  always_comb
  begin
    busAddr = ADDR_W'(bus.address);
    hit     = inWindow(busAddr);
    wrOk    = modeWrites(MODE);
    rdOk    = modeReads(MODE);
    // a write this mode takes wins if both ever arrive together
    wrTake  = bus.write && hit && wrOk;
    rdTake  = bus.read && hit && rdOk && !busy_r && !wrTake;
    rdDone  = busy_r && respReadValid;
  end

  // ********************************
  // forwarding to user logic
  // ********************************
  // address and data hold between commands for slow users
  always_comb
  begin
    userAddr_nxt   = userAddr_r;
    userWrData_nxt = userWrData_r;
    userWrEn_nxt   = wrTake;
    userRdEn_nxt   = rdTake;
    if (wrTake)
    begin
      userAddr_nxt   = winOffset(busAddr);
      userWrData_nxt = DATA_W'(bus.writedata);
    end
    else if (rdTake)
    begin
      userAddr_nxt = winOffset(busAddr);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      userAddr_r   <= '0;
      userWrData_r <= '0;
      userWrEn_r   <= 1'b0;
      userRdEn_r   <= 1'b0;
    end
    else
    begin
      userAddr_r   <= userAddr_nxt;
      userWrData_r <= userWrData_nxt;
      userWrEn_r   <= userWrEn_nxt;
      userRdEn_r   <= userRdEn_nxt;
    end
  end

  // ********************************
  // read return to the bus
  // ********************************
  // a read landing while one is open is dropped, never queued
  always_comb
  begin
    busy_nxt    = busy_r;
    rdData_nxt  = rdData_r;
    rdValid_nxt = 1'b0;
    if (rdTake)
    begin
      busy_nxt = 1'b1;
    end
    // stray valid with no open read is ignored
    if (rdDone)
    begin
      rdData_nxt  = userRdData;
      rdValid_nxt = 1'b1;
      busy_nxt    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      busy_r    <= 1'b0;
      rdData_r  <= '0;
      rdValid_r <= 1'b0;
    end
    else
    begin
      busy_r    <= busy_nxt;
      rdData_r  <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  // ********************************
  // outputs, all straight from flops
  // ********************************
  // narrow words are zero padded onto the bus
  assign userAddr          = userAddr_r;
  assign userWrData        = userWrData_r;
  assign userWrEn          = userWrEn_r;
  assign userRdEn          = userRdEn_r;
  assign bus.readdata      = `RSP_DATA_W'(rdData_r);
  assign bus.readdatavalid = rdValid_r;
endmodule
`default_nettype wire

//--- design/rsp_sim_bus_master.sv
// Purpose: bus master driving single writes and reads onto the bus
// Assumes: one command at a time, reads not pipelined
// Notes:   a read with no answer is dropped after a timeout
`timescale 1ns/1ps
`default_nettype none
`include "rsp_cfg.svh"
module rsp_sim_bus_master
#(
  parameter int ADDR_W = `RSP_ADDR_W,
  parameter int DATA_W = `RSP_DATA_W
)
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  rsp_bus_if.master              bus,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [DATA_W-1:0] cmdWrData,
  input  wire logic              cmdWrite,
  input  wire logic              cmdRead,
  output var  logic              cmdReady,
  output var  logic [DATA_W-1:0] rspData,
  output var  logic              rspValid
);
  import rsp_pkg::*;

  // ********************************
  // command issue and response
  // ********************************
  logic [ADDR_W-1:0] addr_r,  addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic              wr_r,    wr_nxt;
  logic              rd_r,    rd_nxt;
  logic              wait_r,  wait_nxt;
  logic [7:0]        tmo_r,   tmo_nxt;
  logic [DATA_W-1:0] rsp_r,   rsp_nxt;
  logic              rspV_r,  rspV_nxt;

  always_comb
  begin
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    wr_nxt    = 1'b0;
    rd_nxt    = 1'b0;
    wait_nxt  = wait_r;
    tmo_nxt   = tmo_r;
    rsp_nxt   = rsp_r;
    rspV_nxt  = 1'b0;
    if (!wait_r && cmdWrite)
    begin
      addr_nxt  = cmdAddr;
      wdata_nxt = cmdWrData;
      wr_nxt    = 1'b1;
    end
    else if (!wait_r && cmdRead)
    begin
      addr_nxt = cmdAddr;
      rd_nxt   = 1'b1;
      wait_nxt = 1'b1;
      tmo_nxt  = `RSP_RD_TIMEOUT;
    end
    else if (wait_r)
    begin
      if (bus.readdatavalid)
      begin
        rsp_nxt  = DATA_W'(bus.readdata);
        rspV_nxt = 1'b1;
        wait_nxt = 1'b0;
      end
      // unmapped reads never answer; give up
      else if (tmo_r == 8'h00)
      begin
        wait_nxt = 1'b0;
      end
      else
      begin
        tmo_nxt = tmo_r - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      addr_r  <= '0;
      wdata_r <= '0;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      wait_r  <= 1'b0;
      tmo_r   <= 8'h00;
      rsp_r   <= '0;
      rspV_r  <= 1'b0;
    end
    else
    begin
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      wr_r    <= wr_nxt;
      rd_r    <= rd_nxt;
      wait_r  <= wait_nxt;
      tmo_r   <= tmo_nxt;
      rsp_r   <= rsp_nxt;
      rspV_r  <= rspV_nxt;
    end
  end

  assign bus.address   = `RSP_ADDR_W'(addr_r);
  assign bus.writedata = `RSP_DATA_W'(wdata_r);
  assign bus.write     = wr_r;
  assign bus.read      = rd_r;
  assign cmdReady      = !wait_r;
  assign rspData       = rsp_r;
  assign rspValid      = rspV_r;
endmodule
`default_nettype wire

//--- sim/rsp_link_props.sv
// Purpose: bus checks for the region slave link
// Assumes: watched slave is in read/write mode
// Notes:   tracks the one open window read
`timescale 1ns/1ps
`default_nettype none
`include "rsp_cfg.svh"
module rsp_link_props
(
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [15:0] address,
  input wire logic [31:0] writedata,
  input wire logic        write,
  input wire logic        read,
  input wire logic [31:0] readdata,
  input wire logic        readdatavalid
);
  logic pend_r;
  logic pend_nxt;
  logic inWin;
  assign inWin = address >= `RSP_BASE_ADDR
    && address < `RSP_BASE_ADDR + `RSP_NUM_WORDS;
  // ****************
  // open read
  // ****************
  always_comb
  begin
    pend_nxt = pend_r;
    if (readdatavalid) pend_nxt = 1'b0;
    if (read && inWin) pend_nxt = 1'b1;
  end
  always_ff @(posedge ref_clk)
    pend_r <= srst ? 1'b0 : pend_nxt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_win_read;
    read && inWin;
  endsequence
  // user answers within a few cycles, so the bound is short
  sequence s_answer;
    ##[2:16] readdatavalid;
  endsequence
  a_one_command: assert property (!(write && read))
    else $error("write and read together");
  a_answer_has_read: assert property (readdatavalid |-> pend_r)
    else $error("read answer with no open read");
  a_no_pipelined: assert property
    (read |-> !pend_r || readdatavalid)
    else $error("second read while one is open");
  a_single_answer: assert property
    (readdatavalid |=> !readdatavalid)
    else $error("answer longer than one cycle");
  a_read_pulse: assert property (read |=> !read)
    else $error("read longer than one cycle");
  a_read_answered: assert property (s_win_read |-> s_answer)
    else $error("window read not answered");
  a_addr_held: assert property
    (!(write || read) |-> $stable(address))
    else $error("address moved without a command");
  a_reset_quiet: assert property
    ($fell(srst) |-> !write && !read && !readdatavalid)
    else $error("bus pulse straight after reset");
endmodule
`default_nettype wire

//--- sim/tb_rsp_region_slave_port.sv
// Purpose: drives master commands, checks all four window modes
// Assumes: user side answers each forwarded read at once
// Notes:   one master and slave pair per mode, index is the mode
`timescale 1ns/1ps
`default_nettype none
`include "rsp_cfg.svh"
module tb_rsp_region_slave_port;
  import rsp_pkg::*;
  localparam logic [15:0] BASE  = `RSP_BASE_ADDR;
  localparam logic [15:0] WORDS = `RSP_NUM_WORDS;
  logic        ref_clk = 1'b0;
  logic        srst    = 1'b1;
  logic [15:0] cAddr   = '0;
  logic [31:0] cData   = '0;
  logic        cWr     = 1'b0;
  logic        cRd     = 1'b0;
  logic [31:0] rdData  = '0;
  logic [3:0]  rdValid = '0;
  logic [31:0] seed    = 32'h464a;
  logic        wrEn  [4];
  logic        rdEn  [4];
  logic        rspV  [4];
  logic        rdy   [4];
  logic [15:0] uAddr [4];
  logic [31:0] uData [4];
  logic [31:0] rspD  [4];
  int          bad_count = 0;
  int          checks    = 0;
  always #50 ref_clk = ~ref_clk;
  rsp_bus_if bus [4] ();
  for (genvar g = 0; g < 4; g++)
  begin : gen_mode
    rsp_sim_bus_master u_rsp_sim_bus_master
    (
      .ref_clk(ref_clk), .srst(srst), .bus(bus[g]), .cmdAddr(cAddr),
      .cmdWrData(cData), .cmdWrite(cWr), .cmdRead(cRd), .cmdReady(rdy[g]),
      .rspData(rspD[g]), .rspValid(rspV[g])
    );
    rsp_region_slave_port #(.MODE(rsp_mode_type'(g))) u_rsp_region_slave_port
    (
      .ref_clk(ref_clk), .srst(srst), .bus(bus[g]), .userAddr(uAddr[g]),
      .userWrData(uData[g]), .userWrEn(wrEn[g]), .userRdEn(rdEn[g]),
      .userRdData(rdData), .respReadValid(rdValid[g])
    );
  end
  rsp_link_props u_rsp_link_props
  (
    .ref_clk(ref_clk), .srst(srst), .address(bus[2].address),
    .writedata(bus[2].writedata), .write(bus[2].write),
    .read(bus[2].read), .readdata(bus[2].readdata),
    .readdatavalid(bus[2].readdatavalid)
  );
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic hit(input logic [15:0] a);
    return a >= BASE && a < BASE + WORDS;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one command to all four pairs, answered by the user side
  task automatic access(input logic wr, input logic [15:0] a);
    logic [31:0] d;
    logic        wOk;
    logic        rOk;
    d = rnd();
    @(negedge ref_clk);
    cAddr = a;
    cData = d;
    cWr = wr;
    cRd = !wr;
    @(negedge ref_clk);
    cWr = 1'b0;
    cRd = 1'b0;
    @(negedge ref_clk);
    rdData = rnd();
    for (int g = 0; g < 4; g++)
    begin
      wOk = wr && hit(a) && (g == 1 || g == 2);
      rOk = !wr && hit(a) && (g == 0 || g == 2);
      check(32'(wrEn[g]), 32'(wOk));
      check(32'(rdEn[g]), 32'(rOk));
      if (wOk || rOk) check(32'(uAddr[g]), 32'(a - BASE));
      if (wOk) check(uData[g], d);
      rdValid[g] = rdEn[g];
    end
    @(negedge ref_clk);
    rdValid = '0;
    @(negedge ref_clk);
    for (int g = 0; g < 4; g++)
    begin
      rOk = !wr && hit(a) && (g == 0 || g == 2);
      check(32'(rspV[g]), 32'(rOk));
      if (rOk) check(rspD[g], rdData);
      check(32'(rdy[g]), 32'(wr || rOk));
    end
    // refused reads leave masters waiting out their timeout
    if (!wr)
    begin
      repeat (22) @(negedge ref_clk);
      for (int g = 0; g < 4; g++)
      begin
        check(32'(rdy[g]), 32'h0000_0001);
      end
    end
  endtask
  initial
  begin
    logic [15:0] corner [4];
    logic [31:0] r;
    corner = '{BASE - 16'h0001, BASE, BASE + WORDS - 16'h0001, BASE + WORDS};
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    for (int i = 0; i < 8; i++) access(i[0], corner[i / 2]);
    // mid-run reset must drop a read left waiting
    @(negedge ref_clk);
    cAddr = BASE - 16'h0001;
    cRd = 1'b1;
    @(negedge ref_clk);
    cRd = 1'b0;
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    for (int g = 0; g < 4; g++)
    begin
      check(32'(rdy[g]), 32'h0000_0001);
      check(32'(uAddr[g]), 32'h0000_0000);
      check(32'(rspV[g]), 32'h0000_0000);
    end
    for (int i = 0; i < 40; i++)
    begin
      r = rnd();
      access(r[0], 16'h00f8 + 16'(r[12:8]));
    end
    wrap_up();
  end
  initial
  begin
    #(100 * 3000);
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
